//--- jsp_regs.svh
// register indices, field positions, reset values and bus figures of the joystick port
`ifndef JSP_REGS_SVH
`define JSP_REGS_SVH
// register indices; byte address is four times the index
`define JSP_IDX_CTRL      6'h00
`define JSP_IDX_STATUS    6'h02
`define JSP_IDX_IRQ_EN    6'h03
`define JSP_IDX_AX_LOW    6'h04
`define JSP_IDX_AX_HIGH   6'h05
`define JSP_IDX_AY_LOW    6'h06
`define JSP_IDX_AY_HIGH   6'h07
`define JSP_IDX_BX_LOW    6'h08
`define JSP_IDX_CLEAR     6'h0E
`define JSP_IDX_W         6
// control fields
`define JSP_CTRL_ENH      0
// status and enable fields
`define JSP_RDY_AX        0
`define JSP_RDY_AY        1
`define JSP_RDY_BX        2
`define JSP_RDY_BY        3
`define JSP_BTN_LSB       4
`define JSP_BTN_MSB       7
`define JSP_IEN_POS_A     0
`define JSP_IEN_POS_B     1
`define JSP_IEN_EITHER    2
`define JSP_IEN_RSVD      3
// writable mask of the enable register, reserved bit held at zero
`define JSP_IEN_WMASK     8'hF7
// reset values
`define JSP_RST_BYTE      8'h00
`define JSP_RST_WORD      32'h0000_0000
`endif

//--- jsp_pkg.sv
// types shared by the joystick port register bank
package jsp_pkg;
    typedef logic [7:0]  jsp_byte_t;
    typedef logic [15:0] jsp_count_t;
    typedef logic [31:0] jsp_word_t;
endpackage

//--- jsp_top.sv
// joystick port interrupt enable, event/ready status and position byte windows on apb
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "jsp_regs.svh"

// Contract
// - enabled button raises interrupt on its event; enable resets to zero
// - enable bits 7..4 are B button1, B button0, A button1, A button0
// - bit 2 zero needs both counters ready, one accepts either counter ready
// - bit 1 enables joystick B position-complete interrupt, default off
// - enable and counter byte registers only work in enhanced mode
// - each 16-bit counter read as low and high byte, reset zero; here B X has only its low byte and B Y is not mapped
// - writes to counter byte offsets are discarded
// - reading a position counter clears its ready status bit
// - status bits clear by writing one; writing zero does nothing
module jsp_top
    import jsp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire jsp_pkg::jsp_word_t pwdata,
    input  wire logic [3:0]       pstrb,
    output var  jsp_pkg::jsp_word_t prdata,
    output var  logic             pready,
    output var  logic             pslverr,
    // measurement side
    input  wire jsp_pkg::jsp_count_t pos_ax,
    input  wire jsp_pkg::jsp_count_t pos_ay,
    input  wire jsp_pkg::jsp_count_t pos_bx,
    input  wire logic [3:0]       count_done,
    input  wire logic [3:0]       button_event,
    // interrupt and mode
    output var  logic             irq,
    output var  logic             enhanced_mode
);
    import jsp_pkg::*;

    // elaboration check; the index field and the zero test above it need the full byte address
    if (ADDR_W < `JSP_IDX_W + 2) begin : g_addr_w_bad
        $error("jsp_top: ADDR_W too small for register map");
    end

    // index match, shared by read mux, write strobes and read side effects
    function automatic logic hit(input logic [`JSP_IDX_W-1:0] a, input logic [`JSP_IDX_W-1:0] b);
        hit = (a == b);
    endfunction

    jsp_byte_t ctrl_r;
    jsp_byte_t st_r;
    jsp_byte_t st_nxt;
    jsp_byte_t ien_r;
    jsp_word_t prdata_r;
    logic      pready_r;
    logic      pslverr_r;
    logic      irq_r;

    // address decode
    wire logic [`JSP_IDX_W-1:0] idx = paddr[`JSP_IDX_W+1:2];
    wire logic high_zero = (ADDR_W > `JSP_IDX_W + 2) ? (paddr >> (`JSP_IDX_W + 2)) == '0 : 1'b1;
    wire logic aligned   = (paddr[1:0] == 2'b00) && high_zero;
    wire logic enh       = ctrl_r[`JSP_CTRL_ENH];
    wire logic is_ctrl   = hit(idx, `JSP_IDX_CTRL);
    wire logic is_st     = hit(idx, `JSP_IDX_STATUS);
    wire logic is_ien    = hit(idx, `JSP_IDX_IRQ_EN);
    wire logic is_axl    = hit(idx, `JSP_IDX_AX_LOW);
    wire logic is_axh    = hit(idx, `JSP_IDX_AX_HIGH);
    wire logic is_ayl    = hit(idx, `JSP_IDX_AY_LOW);
    wire logic is_ayh    = hit(idx, `JSP_IDX_AY_HIGH);
    wire logic is_bxl    = hit(idx, `JSP_IDX_BX_LOW);
    wire logic is_clr    = hit(idx, `JSP_IDX_CLEAR);
    wire logic is_cnt    = is_axl | is_axh | is_ayl | is_ayh | is_bxl;
    wire logic mapped    = aligned & (is_ctrl | is_st | is_ien | is_cnt | is_clr);

    // apb phases; no wait state, prdata comes from a flop loaded in the setup cycle
    wire logic setup  = psel & ~penable;
    wire logic acc    = psel & penable & pready_r;
    wire logic wr_acc = acc & pwrite & pstrb[0] & mapped;
    wire logic rd_acc = acc & ~pwrite & mapped;

    // counter offsets carry no write strobe at all
    wire logic wr_ctrl = wr_acc & is_ctrl;
    wire logic wr_ien  = wr_acc & is_ien & enh;
    wire logic wr_w1c  = wr_acc & (is_st | is_clr) & enh;

    // read mux; legacy mode hides all enhanced registers
    jsp_byte_t rd_byte;
    always_comb begin
        rd_byte = `JSP_RST_BYTE;
        if (aligned && is_ctrl)
            rd_byte = ctrl_r;
        else if (aligned && enh) begin
            if (is_st)  rd_byte = st_r;
            if (is_ien) rd_byte = ien_r & `JSP_IEN_WMASK;
            if (is_axl) rd_byte = pos_ax[7:0];
            if (is_axh) rd_byte = pos_ax[15:8];
            if (is_ayl) rd_byte = pos_ay[7:0];
            if (is_ayh) rd_byte = pos_ay[15:8];
            if (is_bxl) rd_byte = pos_bx[7:0];
        end
    end

    // a counter is done being read at its last byte; B X has only its low byte here
    wire logic [3:0] rd_clr = {1'b0,
                               rd_acc & enh & is_bxl,
                               rd_acc & enh & is_ayh,
                               rd_acc & enh & is_axh};
    wire jsp_byte_t clr_mask = wr_w1c ? pwdata[7:0] : `JSP_RST_BYTE;
    wire jsp_byte_t set_mask = enh ? {button_event, count_done} : `JSP_RST_BYTE;

    // set beats clear so an event in the clearing cycle survives
    always_comb begin
        st_nxt = (st_r & ~clr_mask & ~{4'h0, rd_clr}) | set_mask;
    end

    // interrupt terms
    wire logic either  = ien_r[`JSP_IEN_EITHER];
    wire logic [1:0] ra = st_r[`JSP_RDY_AY:`JSP_RDY_AX];
    wire logic [1:0] rb = st_r[`JSP_RDY_BY:`JSP_RDY_BX];
    wire logic pos_a   = either ? |ra : &ra;
    wire logic pos_b   = either ? |rb : &rb;
    wire logic btn_irq = |(st_r[`JSP_BTN_MSB:`JSP_BTN_LSB] & ien_r[`JSP_BTN_MSB:`JSP_BTN_LSB]);
    wire logic irq_nxt = enh & (btn_irq
                                | (ien_r[`JSP_IEN_POS_A] & pos_a)
                                | (ien_r[`JSP_IEN_POS_B] & pos_b));

    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_r <= `JSP_RST_BYTE;
        else if (wr_ctrl)
            ctrl_r <= {7'h00, pwdata[`JSP_CTRL_ENH]};
    end

    // interrupt enable, reserved bit never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ien_r <= `JSP_RST_BYTE;
        else if (wr_ien)
            ien_r <= pwdata[7:0] & `JSP_IEN_WMASK;
    end

    // sticky status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            st_r <= `JSP_RST_BYTE;
        else
            st_r <= st_nxt;
    end

    // apb answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `JSP_RST_WORD;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r  <= (setup && !pwrite) ? {24'h000000, rd_byte} : `JSP_RST_WORD;
        end
    end

    // interrupt flop; level stays while any enabled term stays set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_r <= 1'b0;
        else
            irq_r <= irq_nxt;
    end

    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign irq           = irq_r;
    assign enhanced_mode = ctrl_r[`JSP_CTRL_ENH];

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup_rd(logic sel);
        setup && !pwrite && aligned && sel && enh;
    endsequence

    sequence s_w1c_write(int b);
        wr_w1c && pwdata[b] && !set_mask[b];
    endsequence

    chk_btn_gate: assert property (
        enh && (ien_r[7:4] == 4'h0) && !ien_r[0] && !ien_r[1] |=> !irq_r)
        else $error("button interrupt without enable");

    chk_btn_map: assert property (
        enh && st_r[7] && ien_r[7] |=> irq_r)
        else $error("bit 7 enable does not map to B button 1");

    chk_pos_both: assert property (
        enh && ien_r == 8'h01 && st_r == 8'h01 |=> !irq_r)
        else $error("position irq with only one counter ready in both-mode");

    chk_pos_either: assert property (
        enh && ien_r == 8'h05 && st_r[1:0] == 2'b10 |=> irq_r)
        else $error("position irq missing in either-mode");

    chk_devb_pos: assert property (
        enh && ien_r[1] && st_r[3:2] == 2'b11 |=> irq_r)
        else $error("joystick B position irq missing");

    chk_deva_pos: assert property (
        enh && ien_r[0] && st_r[1:0] == 2'b11 |=> irq_r)
        else $error("joystick A position irq missing");

    chk_rsvd_bit: assert property (!ien_r[3])
        else $error("reserved enable bit set");

    chk_legacy_quiet: assert property (
        !enh |=> !irq_r ##0 $stable(ien_r))
        else $error("legacy mode irq or enable change");

    chk_rd_data: assert property (
        s_setup_rd(is_axh) |=> prdata_r == {24'h000000, $past(pos_ax[15:8])})
        else $error("counter high byte read wrong");

    chk_wr_ignored: assert property (
        acc && pwrite && is_cnt |=> $stable(ien_r) && $stable(ctrl_r))
        else $error("counter offset write changed state");

    chk_rd_clear: assert property (
        rd_acc && enh && is_axh && !count_done[0] |=> !st_r[0])
        else $error("ready not cleared by counter read");

    chk_w1c_clear: assert property (
        s_w1c_write(4) |=> !st_r[4])
        else $error("write one did not clear status");

    chk_w0_keep: assert property (
        st_r[5] && !(rd_acc) && !(wr_w1c && pwdata[5]) |=> st_r[5])
        else $error("status bit lost without write one");

    // irq trails status by one cycle, so an access in the cycle before also excuses a drop
    chk_irq_hold: assert property (
        irq_r && !acc && !$past(acc) |=> irq_r)
        else $error("interrupt dropped without software clear");

    chk_legacy_status: assert property (
        !enh |=> $stable(st_r))
        else $error("legacy mode status changed");

    chk_legacy_read: assert property (
        setup && !pwrite && aligned && !is_ctrl && !enh |=> prdata_r == `JSP_RST_WORD)
        else $error("legacy mode read returned data");

    chk_cnt_wr_status: assert property (
        acc && pwrite && is_cnt && (set_mask == `JSP_RST_BYTE) |=> $stable(st_r))
        else $error("counter offset write changed status");

    chk_set_wins: assert property (
        enh && count_done[0] |=> st_r[0])
        else $error("ready event lost against a clear");

    chk_bx_clear: assert property (
        rd_acc && enh && is_bxl && !count_done[2] |=> !st_r[2])
        else $error("B X ready not cleared by low byte read");

    chk_ay_clear: assert property (
        rd_acc && enh && is_ayh && !count_done[1] |=> !st_r[1])
        else $error("A Y ready not cleared by high byte read");

    chk_low_keep: assert property (
        st_r[0] && rd_acc && is_axl |=> st_r[0])
        else $error("A X ready cleared by low byte read");

    chk_ien_write: assert property (
        wr_ien |=> ien_r == (8'($past(pwdata)) & `JSP_IEN_WMASK))
        else $error("enable write did not land");

    chk_clr_alias: assert property (
        wr_w1c && is_clr && pwdata[6] && !set_mask[6] |=> !st_r[6])
        else $error("clear alias did not clear status");

    chk_pos_b_both: assert property (
        enh && ien_r == 8'h02 && st_r[3:2] == 2'b01 |=> !irq_r)
        else $error("B position irq with one counter ready in both-mode");

    chk_btn_a0_map: assert property (
        enh && st_r[4] && ien_r[4] |=> irq_r)
        else $error("bit 4 enable does not map to A button 0");

    chk_rd_low: assert property (
        s_setup_rd(is_axl) |=> prdata_r == {24'h000000, $past(pos_ax[7:0])})
        else $error("counter low byte read wrong");

endmodule // jsp_top
`default_nettype wire

//--- tb.sv
// self-checking bench of the joystick port interrupt enable, status and position windows
`timescale 1ns/1ps
`default_nettype none
`include "jsp_regs.svh"
module tb;
    import jsp_pkg::*;
    logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, enhanced_mode, err;
    logic [7:0] paddr, st_m, ien_m;
    logic [3:0] pstrb, count_done, button_event;
    jsp_word_t  pwdata, prdata, rd;
    jsp_count_t pos_ax, pos_ay, pos_bx;
    logic [15:0] rnd;
    int         fail_count, cmp_count, cyc;

    jsp_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pos_ax(pos_ax), .pos_ay(pos_ay), .pos_bx(pos_bx), .count_done(count_done),
        .button_event(button_event), .irq(irq), .enhanced_mode(enhanced_mode));

    // clock generation
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // cycle ceiling so a hung handshake still ends the run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // expected interrupt level from modelled status and enables
    function automatic logic exp_irq(input logic [7:0] s, input logic [7:0] e);
        logic pa, pb;
        pa = e[2] ? |s[1:0] : &s[1:0];
        pb = e[2] ? |s[3:2] : &s[3:2];
        return |(s[7:4] & e[7:4]) | (e[0] & pa) | (e[1] & pb);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    // one apb transfer; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input logic [3:0] cd, input logic [3:0] be);
        @(posedge pclk);
        count_done   <= cd;
        button_event <= be;
        @(posedge pclk);
        count_done   <= 4'h0;
        button_event <= 4'h0;
    endtask

    task automatic chk_irq();
        repeat (2) @(posedge pclk);
        #1 chk({31'h0, irq}, {31'h0, exp_irq(st_m, ien_m)});
    endtask

    // one pass: enable, events, ordered counter reads, clear; reads honour the ready bits
    task automatic step(input logic [7:0] ie, input logic [3:0] cd, input logic [3:0] be, input logic [7:0] m);
        rnd = lfsr(rnd);
        @(posedge pclk);
        pos_ax <= rnd;
        pos_ay <= ~rnd;
        pos_bx <= {rnd[7:0], rnd[15:8]};
        apb(1'b1, `JSP_IDX_IRQ_EN, ie);
        ien_m = ie & 8'hF7;
        apb(1'b0, `JSP_IDX_IRQ_EN, 8'h00);
        chk(rd, {24'h0, ien_m});
        pulse(cd, be);
        st_m = st_m | {be, cd};
        chk_irq();
        apb(1'b1, `JSP_IDX_AX_LOW, rnd[15:8]);
        if (st_m[0]) begin
            apb(1'b0, `JSP_IDX_AX_LOW, 8'h00);
            chk(rd, {24'h0, pos_ax[7:0]});
            apb(1'b0, `JSP_IDX_AX_HIGH, 8'h00);
            chk(rd, {24'h0, pos_ax[15:8]});
            st_m[0] = 1'b0;
        end
        if (st_m[1]) begin
            apb(1'b0, `JSP_IDX_AY_LOW, 8'h00);
            chk(rd, {24'h0, pos_ay[7:0]});
            apb(1'b0, `JSP_IDX_AY_HIGH, 8'h00);
            chk(rd, {24'h0, pos_ay[15:8]});
            st_m[1] = 1'b0;
        end
        if (st_m[2]) begin
            apb(1'b0, `JSP_IDX_BX_LOW, 8'h00);
            chk(rd, {24'h0, pos_bx[7:0]});
            st_m[2] = 1'b0;
        end
        apb(1'b1, `JSP_IDX_STATUS, 8'h00);
        apb(1'b0, `JSP_IDX_STATUS, 8'h00);
        chk(rd, {24'h0, st_m});
        chk_irq();
        apb(1'b1, `JSP_IDX_STATUS, m);
        st_m = st_m & ~m;
        apb(1'b0, `JSP_IDX_STATUS, 8'h00);
        chk(rd, {24'h0, st_m});
        chk_irq();
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence: legacy mode, corner table, then random passes
    initial begin
        {psel, penable, pwrite, paddr, pwdata, count_done, button_event} = '0;
        {pos_ax, pos_ay, pos_bx, st_m, ien_m, fail_count, cmp_count, cyc} = '0;
        pstrb   = 4'hF;
        presetn = 1'b0;
        rnd     = 16'h0047;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `JSP_IDX_IRQ_EN, 8'hFF);
        pulse(4'hF, 4'hF);
        chk_irq();
        chk({31'h0, enhanced_mode}, 32'h0);
        apb(1'b1, `JSP_IDX_CTRL, 8'h01);
        apb(1'b0, `JSP_IDX_IRQ_EN, 8'h00);
        chk(rd, 32'h0);
        chk({31'h0, enhanced_mode}, 32'h1);
        apb(1'b0, `JSP_IDX_STATUS, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, `JSP_IDX_AX_HIGH, 8'h00);
        chk(rd, 32'h0);
        apb(1'b0, 6'h01, 8'h00);
        chk({31'h0, err}, 32'h1);
        step(8'h01, 4'h1, 4'h0, 8'hFF);
        step(8'h01, 4'h3, 4'h0, 8'hFF);
        step(8'h05, 4'h1, 4'h0, 8'hFF);
        step(8'h02, 4'h4, 4'h0, 8'hFF);
        step(8'h06, 4'h8, 4'h0, 8'hFF);
        step(8'h0F, 4'h0, 4'hF, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            step(8'h10 << i, 4'h0, 4'hF, 8'hF0);
        end
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            step(rnd[7:0], rnd[11:8], rnd[15:12], rnd[8:1]);
        end
        // byte strobe low: the enable write must not land
        pstrb <= 4'h0;
        apb(1'b1, `JSP_IDX_IRQ_EN, ~ien_m);
        pstrb <= 4'hF;
        apb(1'b0, `JSP_IDX_IRQ_EN, 8'h00);
        chk(rd, {24'h0, ien_m});
        // clear alias: set all buttons, clear two of them through the alias
        pulse(4'h0, 4'hF);
        st_m = st_m | 8'hF0;
        apb(1'b1, `JSP_IDX_CLEAR, 8'h50);
        st_m = st_m & ~8'h50;
        apb(1'b0, `JSP_IDX_STATUS, 8'h00);
        chk(rd, {24'h0, st_m});
        chk_irq();
        apb(1'b0, `JSP_IDX_CLEAR, 8'h00);
        chk(rd, 32'h0);
        complete_run();
    end
endmodule // tb
`default_nettype wire
